/* inc/aur_pkg.sv */
// Shared constants, field layout and helpers of the serial receiver/transmitter.
// Assumes a single 20 MHz system clock; bit clocks arrive as sampled pins.
package aur_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_TXDATA = 5'h04;
  localparam logic [4:0] ADDR_RXDATA = 5'h08;
  localparam logic [4:0] ADDR_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h14;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h18;
  localparam logic [4:0] ADDR_CLEAR = 5'h1C;

  // Format control fields, common to both directions
  localparam int CTRL_W = 5;
  localparam int CTRL_LEN_LO = 0;
  localparam int CTRL_LEN_HI = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_SENSE = 3;
  localparam int CTRL_OMIT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  localparam int ST_PERR = 0;
  localparam int ST_FERR = 1;
  localparam int ST_OVR = 2;
  localparam int ST_DAV = 3;
  localparam int ST_TBMT = 4;
  localparam int ST_EOC = 5;

  localparam int IRQ_W = 3;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_ERR = 2;

  // Sixteen bit-clock ticks per bit; centre sample after eight ticks
  localparam int BIT_TICKS = 16;
  localparam logic [3:0] TICK_LAST = 4'(BIT_TICKS - 1);
  localparam logic [3:0] TICK_CENTRE = 4'(BIT_TICKS / 2 - 1);
  localparam logic [3:0] MIN_BITS = 4'h5;

  typedef enum logic [4:0] {
    AUR_IDLE = 5'h01,
    AUR_START = 5'h02,
    AUR_DATA = 5'h04,
    AUR_PARITY = 5'h08,
    AUR_STOP = 5'h10
  } aur_state_t;

  function automatic logic [3:0] data_bits(input logic [1:0] len);
    data_bits = MIN_BITS + {2'h0, len};
  endfunction

  // Sense high selects even parity
  function automatic logic parity_of(input logic [7:0] data, input logic sense);
    parity_of = (^data) ^ ~sense;
  endfunction
endpackage

/* src/aur_rx.sv */
// Receive shifter: start detect, centre sampling, parity and stop checks.
// Assumes serial_bit and tick are already synchronous to clk.
module aur_rx (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic tick,
  input wire logic serial_bit,
  input wire logic [1:0] len,
  input wire logic omit,
  input wire logic sense,
  output logic done,
  output logic [7:0] data,
  output logic perr,
  output logic ferr
);
  aur_pkg::aur_state_t state, next_state;
  logic [3:0] cnt, next_cnt;
  logic [2:0] idx, next_idx;
  logic [7:0] next_data;
  logic next_done, next_perr, next_ferr;

  always_comb begin
    next_state = state;
    next_cnt = tick ? cnt + 4'h1 : cnt;
    next_idx = idx;
    next_data = data;
    next_done = 1'b0;
    next_perr = perr;
    next_ferr = ferr;
    unique case (state)
      aur_pkg::AUR_IDLE: begin
        next_cnt = 4'h0;
        if (tick && !serial_bit) begin
          next_state = aur_pkg::AUR_START;
        end
      end
      aur_pkg::AUR_START: begin
        if (tick && cnt == aur_pkg::TICK_CENTRE) begin
          next_cnt = 4'h0;
          next_idx = 3'h0;
          next_data = 8'h00;
          // A short glitch is rejected here rather than framed as a character
          next_state = serial_bit ? aur_pkg::AUR_IDLE : aur_pkg::AUR_DATA;
        end
      end
      aur_pkg::AUR_DATA: begin
        if (tick && cnt == aur_pkg::TICK_LAST) begin
          next_data[idx] = serial_bit;
          next_idx = idx + 3'h1;
          if ({1'b0, idx} == aur_pkg::data_bits(len) - 4'h1) begin
            next_state = omit ? aur_pkg::AUR_STOP : aur_pkg::AUR_PARITY;
          end
        end
      end
      aur_pkg::AUR_PARITY: begin
        if (tick && cnt == aur_pkg::TICK_LAST) begin
          next_perr = serial_bit != aur_pkg::parity_of(data, sense);
          next_state = aur_pkg::AUR_STOP;
        end
      end
      aur_pkg::AUR_STOP: begin
        if (tick && cnt == aur_pkg::TICK_LAST) begin
          next_ferr = !serial_bit;
          if (omit) begin
            next_perr = 1'b0;
          end
          next_done = 1'b1;
          next_state = aur_pkg::AUR_IDLE;
        end
      end
      default: next_state = aur_pkg::AUR_IDLE;
    endcase
    if (clear) begin
      next_state = aur_pkg::AUR_IDLE;
      next_data = 8'h00;
      next_done = 1'b0;
      next_perr = 1'b0;
      next_ferr = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= aur_pkg::AUR_IDLE;
      cnt <= 4'h0;
      idx <= 3'h0;
      data <= 8'h00;
      done <= 1'b0;
      perr <= 1'b0;
      ferr <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      data <= next_data;
      done <= next_done;
      perr <= next_perr;
      ferr <= next_ferr;
    end
  end
endmodule // aur_rx

/* src/aur_top.sv */
// Serial receiver/transmitter with Avalon-MM register access and tri-state host pins.
// Assumes bit clocks, serial input and enables are asynchronous pins; one system clock.
// Notes on behaviour
// - Receiver and transmitter each step on their own bit clock.
// - Transmit character sent with start, optional parity and stop bits.
// - Character length selectable as 5, 6, 7 or 8 bits.
// - Odd, even or no parity; one or two stop bits.
// - One format control set serves both directions.
// - Received serial bits presented as a parallel character.
// - Parity and stop faults each reported on their own flag.
// - Holding buffer and output buffer double buffer both directions.
// - Overrun flagged when a character lands before the previous was read.
// - Each received bit sampled at the centre of its period.
// - Received data and status pins are tri-state with enables.
// - Master clear empties shifters and clears data, fault and overrun flags; interrupt status is kept; not needed after reset.
// - Fully static; stopped bit clocks simply hold state.
// - With parity omitted no parity bit is sent and parity fault stays low.
// - Serial output idles high.
//
// The Avalon-MM slave port and the address map were decided locally.
module aur_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [aur_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tx_bit_clock,
  input wire logic rx_bit_clock,
  input wire logic serial_in,
  input wire logic master_clear,
  input wire logic rx_data_enable_n,
  input wire logic status_enable_n,
  output logic serial_out,
  output logic end_of_char,
  output logic [7:0] rx_parallel_out,
  output logic rx_parallel_oe_n,
  output logic parity_fault_flag,
  output logic framing_fault_flag,
  output logic overrun_flag,
  output logic data_avail_flag,
  output logic tx_empty_flag,
  output logic status_oe_n,
  output logic irq
);
  // Pin synchronisers; stage one feeds only stage two
  localparam int NSYNC = 6;
  // Idle level of each pin; a clear stage reset high would swallow the first bus write
  localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h37;
  logic [NSYNC-1:0] pin_raw, pin_s1, pin_s2, pin_s3;
  assign pin_raw = {status_enable_n, rx_data_enable_n, master_clear, serial_in,
                    rx_bit_clock, tx_bit_clock};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= SYNC_IDLE;
      pin_s2 <= SYNC_IDLE;
      pin_s3 <= SYNC_IDLE;
    end else if (clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  logic tx_tick, rx_tick, rx_line, clear_pin;
  assign tx_tick = pin_s2[0] & ~pin_s3[0];
  assign rx_tick = pin_s2[1] & ~pin_s3[1];
  assign rx_line = pin_s2[2];
  assign clear_pin = pin_s2[3];

  // Bus slave: one wait cycle, effects land on the edge that waitrequest is low
  logic served, next_served;
  logic [31:0] next_readdata;
  logic req, acc, wr_acc, rd_acc;
  logic [aur_pkg::CTRL_W-1:0] ctrl, next_ctrl;
  logic [aur_pkg::IRQ_W-1:0] irq_status, next_irq_status, irq_enable, next_irq_enable;
  logic [aur_pkg::IRQ_W-1:0] events;
  logic [7:0] hold, next_hold;
  logic hold_full, next_hold_full;
  logic dav, next_dav, perr_f, next_perr_f, ferr_f, next_ferr_f, ovr, next_ovr;
  logic [7:0] rx_buf, next_rx_buf;
  logic clear;

  assign req = avs_read | avs_write;
  assign acc = req & served;
  assign wr_acc = avs_write & served;
  assign rd_acc = avs_read & served;
  assign avs_waitrequest = req & ~served;
  assign clear = clear_pin | (wr_acc && avs_address == aur_pkg::ADDR_CLEAR);

  always_comb begin
    next_served = req & ~served;
    next_readdata = avs_readdata;
    next_ctrl = ctrl;
    next_irq_enable = irq_enable;
    if (req && !served) begin
      unique case (avs_address)
        aur_pkg::ADDR_CTRL: next_readdata = {27'h0, ctrl};
        aur_pkg::ADDR_TXDATA: next_readdata = {24'h0, hold};
        aur_pkg::ADDR_RXDATA: next_readdata = {24'h0, rx_buf};
        aur_pkg::ADDR_STATUS: next_readdata = {26'h0, end_of_char, ~hold_full, dav, ovr,
                                               ferr_f, perr_f};
        aur_pkg::ADDR_IRQ_STATUS: next_readdata = {29'h0, irq_status};
        aur_pkg::ADDR_IRQ_ENABLE: next_readdata = {29'h0, irq_enable};
        default: next_readdata = 32'h0;
      endcase
    end
    if (wr_acc && avs_address == aur_pkg::ADDR_CTRL) begin
      next_ctrl = avs_writedata[aur_pkg::CTRL_W-1:0];
    end
    if (wr_acc && avs_address == aur_pkg::ADDR_IRQ_ENABLE) begin
      next_irq_enable = avs_writedata[aur_pkg::IRQ_W-1:0];
    end
    next_irq_status = irq_status;
    if (wr_acc && avs_address == aur_pkg::ADDR_IRQ_CLEAR) begin
      next_irq_status = irq_status & ~avs_writedata[aur_pkg::IRQ_W-1:0];
    end
    // Set after clear so a same-cycle event is kept
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      served <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl <= aur_pkg::CTRL_RESET;
      irq_status <= '0;
      irq_enable <= '0;
    end else if (clk_en) begin
      served <= next_served;
      avs_readdata <= next_readdata;
      ctrl <= next_ctrl;
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
    end
  end

  assign irq = |(irq_status & irq_enable);

  logic [1:0] len;
  logic two_stop, sense, omit;
  assign len = {ctrl[aur_pkg::CTRL_LEN_HI], ctrl[aur_pkg::CTRL_LEN_LO]};
  assign two_stop = ctrl[aur_pkg::CTRL_STOP];
  assign sense = ctrl[aur_pkg::CTRL_SENSE];
  assign omit = ctrl[aur_pkg::CTRL_OMIT];

  // Transmitter
  aur_pkg::aur_state_t tx_state, next_tx_state;
  logic [3:0] tx_cnt, next_tx_cnt;
  logic [2:0] tx_idx, next_tx_idx;
  logic tx_stop2, next_tx_stop2, tx_par, next_tx_par, next_so, next_eoc, bit_end;
  logic [7:0] tx_shift, next_tx_shift, masked;
  assign bit_end = tx_tick && tx_cnt == aur_pkg::TICK_LAST;
  assign masked = hold & 8'(~(8'hFF << aur_pkg::data_bits(len)));

  always_comb begin
    next_tx_state = tx_state;
    next_tx_cnt = tx_tick ? tx_cnt + 4'h1 : tx_cnt;
    next_tx_idx = tx_idx;
    next_tx_stop2 = tx_stop2;
    next_tx_par = tx_par;
    next_tx_shift = tx_shift;
    next_hold = hold;
    next_hold_full = hold_full;
    next_eoc = end_of_char;
    unique case (tx_state)
      aur_pkg::AUR_IDLE: begin
        next_tx_cnt = 4'h0;
        next_eoc = 1'b1;
        if (hold_full) begin
          next_tx_shift = masked;
          next_tx_par = aur_pkg::parity_of(masked, sense);
          next_hold_full = 1'b0;
          next_eoc = 1'b0;
          next_tx_state = aur_pkg::AUR_START;
        end
      end
      aur_pkg::AUR_START: begin
        if (bit_end) begin
          next_tx_idx = 3'h0;
          next_tx_state = aur_pkg::AUR_DATA;
        end
      end
      aur_pkg::AUR_DATA: begin
        if (bit_end) begin
          next_tx_shift = {1'b0, tx_shift[7:1]};
          next_tx_idx = tx_idx + 3'h1;
          if ({1'b0, tx_idx} == aur_pkg::data_bits(len) - 4'h1) begin
            next_tx_stop2 = 1'b0;
            next_tx_state = omit ? aur_pkg::AUR_STOP : aur_pkg::AUR_PARITY;
          end
        end
      end
      aur_pkg::AUR_PARITY: begin
        if (bit_end) begin
          next_tx_stop2 = 1'b0;
          next_tx_state = aur_pkg::AUR_STOP;
        end
      end
      aur_pkg::AUR_STOP: begin
        if (bit_end) begin
          if (two_stop && !tx_stop2) begin
            next_tx_stop2 = 1'b1;
          end else begin
            // Back-to-back characters show end of character for one cycle only
            next_eoc = 1'b1;
            next_tx_state = aur_pkg::AUR_IDLE;
          end
        end
      end
      default: next_tx_state = aur_pkg::AUR_IDLE;
    endcase
    if (wr_acc && avs_address == aur_pkg::ADDR_TXDATA) begin
      next_hold = avs_writedata[7:0];
      next_hold_full = 1'b1;
    end
    if (clear) begin
      next_tx_state = aur_pkg::AUR_IDLE;
      next_hold_full = 1'b0;
      next_tx_shift = 8'h00;
      next_eoc = 1'b1;
    end
    unique case (next_tx_state)
      aur_pkg::AUR_START: next_so = 1'b0;
      aur_pkg::AUR_DATA: next_so = next_tx_shift[0];
      aur_pkg::AUR_PARITY: next_so = next_tx_par;
      default: next_so = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= aur_pkg::AUR_IDLE;
      tx_cnt <= 4'h0;
      tx_idx <= 3'h0;
      tx_stop2 <= 1'b0;
      tx_par <= 1'b0;
      tx_shift <= 8'h00;
      hold <= 8'h00;
      hold_full <= 1'b0;
      serial_out <= 1'b1;
      end_of_char <= 1'b1;
    end else if (clk_en) begin
      tx_state <= next_tx_state;
      tx_cnt <= next_tx_cnt;
      tx_idx <= next_tx_idx;
      tx_stop2 <= next_tx_stop2;
      tx_par <= next_tx_par;
      tx_shift <= next_tx_shift;
      hold <= next_hold;
      hold_full <= next_hold_full;
      serial_out <= next_so;
      end_of_char <= next_eoc;
    end
  end

  // Receiver and its output buffer
  logic rx_done, rx_perr, rx_ferr;
  logic [7:0] rx_data;

  aur_rx u_rx (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .clear(clear),
    .tick(rx_tick),
    .serial_bit(rx_line),
    .len(len),
    .omit(omit),
    .sense(sense),
    .done(rx_done),
    .data(rx_data),
    .perr(rx_perr),
    .ferr(rx_ferr)
  );

  always_comb begin
    next_rx_buf = rx_buf;
    next_dav = dav;
    next_perr_f = perr_f;
    next_ferr_f = ferr_f;
    next_ovr = ovr;
    if (rd_acc && avs_address == aur_pkg::ADDR_RXDATA) begin
      next_dav = 1'b0;
    end
    if (rx_done) begin
      next_rx_buf = rx_data;
      next_perr_f = rx_perr;
      next_ferr_f = rx_ferr;
      next_ovr = dav;
      next_dav = 1'b1;
    end
    if (clear) begin
      next_dav = 1'b0;
      next_perr_f = 1'b0;
      next_ferr_f = 1'b0;
      next_ovr = 1'b0;
    end
    events = '0;
    events[aur_pkg::IRQ_RX] = rx_done;
    events[aur_pkg::IRQ_ERR] = rx_done & (rx_perr | rx_ferr | dav);
    events[aur_pkg::IRQ_TX] = hold_full & ~next_hold_full & ~clear;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_buf <= 8'h00;
      dav <= 1'b0;
      perr_f <= 1'b0;
      ferr_f <= 1'b0;
      ovr <= 1'b0;
    end else if (clk_en) begin
      rx_buf <= next_rx_buf;
      dav <= next_dav;
      perr_f <= next_perr_f;
      ferr_f <= next_ferr_f;
      ovr <= next_ovr;
    end
  end

  // Tri-state host pins; enables pass the synchronisers so add two cycles of latency
  assign rx_parallel_out = rx_buf;
  assign rx_parallel_oe_n = pin_s2[4];
  assign status_oe_n = pin_s2[5];
  assign parity_fault_flag = perr_f;
  assign framing_fault_flag = ferr_f;
  assign overrun_flag = ovr;
  assign data_avail_flag = dav;
  assign tx_empty_flag = ~hold_full;
endmodule // aur_top

/* verif/aur_sva.sv */
// Concurrent checks on the pins of the serial receiver/transmitter top.
// Assumes one system clock and that the bench holds clk_en high.
module aur_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic tx_bit_clock,
  input wire logic master_clear,
  input wire logic rx_data_enable_n,
  input wire logic status_enable_n,
  input wire logic serial_out,
  input wire logic end_of_char,
  input wire logic rx_parallel_oe_n,
  input wire logic parity_fault_flag,
  input wire logic framing_fault_flag,
  input wire logic overrun_flag,
  input wire logic data_avail_flag,
  input wire logic tx_empty_flag,
  input wire logic status_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic tck_q;
  logic eoc_q;
  logic [4:0] start_ticks;
  logic [4:0] next_start_ticks;
  // Pin ticks lead the design's synced ticks, so the count is a safe upper bound
  always_comb begin
    next_start_ticks = start_ticks;
    if (eoc_q && !end_of_char) next_start_ticks = 5'h00;
    else if (tx_bit_clock && !tck_q && start_ticks != 5'h1F) begin
      next_start_ticks = start_ticks + 5'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tck_q <= 1'b0;
      eoc_q <= 1'b1;
      start_ticks <= 5'h1F;
    end else begin
      tck_q <= tx_bit_clock;
      eoc_q <= end_of_char;
      start_ticks <= next_start_ticks;
    end
  end
  property p_idle_mark; end_of_char |-> serial_out; endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("serial out low while idle");
  property p_start_low; (!end_of_char && start_ticks <= 5'h0D) |-> !serial_out; endproperty
  a_start_low: assert property (p_start_low) else $error("start bit too short");
  property p_rx_oe; rx_parallel_oe_n == $past(rx_data_enable_n, 2); endproperty
  a_rx_oe: assert property (p_rx_oe) else $error("data enable not followed");
  property p_st_oe; status_oe_n == $past(status_enable_n, 2); endproperty
  a_st_oe: assert property (p_st_oe) else $error("status enable not followed");
  property p_ovr; $rose(overrun_flag) |-> $past(data_avail_flag); endproperty
  a_ovr: assert property (p_ovr) else $error("overrun without unread char");
  property p_err_dav; ($rose(parity_fault_flag) || $rose(framing_fault_flag)) |-> data_avail_flag;
  endproperty
  a_err_dav: assert property (p_err_dav) else $error("fault flag without char");
  property p_clear;
    master_clear [*6] |-> !(data_avail_flag || overrun_flag || parity_fault_flag ||
      framing_fault_flag) && tx_empty_flag && serial_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state");
  property p_refill; ($rose(end_of_char) && !tx_empty_flag) |-> ##[1:4] tx_empty_flag; endproperty
  a_refill: assert property (p_refill) else $error("holding char not moved");
  property p_wait_one; ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_wait_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
  c_frame: cover property ($fell(end_of_char));
  c_ovr: cover property ($rose(overrun_flag));
  c_perr: cover property ($rose(parity_fault_flag));
  c_ferr: cover property ($rose(framing_fault_flag));
endmodule // aur_sva

bind aur_top aur_sva i_aur_sva (.clk, .reset_n, .avs_read, .avs_write, .avs_waitrequest,
  .tx_bit_clock, .master_clear, .rx_data_enable_n, .status_enable_n, .serial_out,
  .end_of_char, .rx_parallel_oe_n, .parity_fault_flag, .framing_fault_flag, .overrun_flag,
  .data_avail_flag, .tx_empty_flag, .status_oe_n);

/* verif/aur_station.sv */
// Remote serial station: sends frames on the receive line, collects transmitted frames.
// Assumes both bit clocks run free at sixteen ticks per bit.
module aur_station (
  input wire logic rx_bit_clock,
  input wire logic tx_bit_clock,
  input wire logic serial_out,
  input wire logic [3:0] frame_bits,
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] frames[$];
  initial serial_in = 1'b1;
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      serial_in <= bits[i];
      repeat (16) @(posedge rx_bit_clock);
    end
    serial_in <= 1'b1;
    repeat (32) @(posedge rx_bit_clock);
  endtask
  // Centre sampling keeps us clear of the design's sync lag on each edge
  always begin : collect
    logic [11:0] b;
    @(posedge tx_bit_clock);
    if (serial_out === 1'b0) begin
      b = 12'h000;
      repeat (7) @(posedge tx_bit_clock);
      for (int i = 0; i < frame_bits; i++) begin
        b[i] = serial_out;
        if (i < frame_bits - 1) repeat (16) @(posedge tx_bit_clock);
      end
      frames.push_back(b);
    end
  end
endmodule // aur_station

/* verif/aur_top_tb_top.sv */
// Self-checking bench for the serial receiver/transmitter top.
// Assumes free-running bit clocks and one remote station on the serial lines.
module aur_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
  localparam logic [4:0] FMT [4] = '{5'h00, 5'h0D, 5'h12, 5'h07};
  int fail_count = 0;
  int checks_done = 0;
  logic clk, reset_n, avs_read, avs_write, avs_waitrequest, tx_bit_clock, rx_bit_clock;
  logic serial_in, master_clear, rx_data_enable_n, status_enable_n, serial_out, end_of_char;
  logic rx_parallel_oe_n, parity_fault_flag, framing_fault_flag, overrun_flag, irq;
  logic data_avail_flag, tx_empty_flag, status_oe_n;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [7:0] rx_parallel_out;
  logic [3:0] frame_bits;
  aur_top i_aur_top (.clk, .reset_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .tx_bit_clock, .rx_bit_clock,
    .serial_in, .master_clear, .rx_data_enable_n, .status_enable_n, .serial_out,
    .end_of_char, .rx_parallel_out, .rx_parallel_oe_n, .parity_fault_flag,
    .framing_fault_flag, .overrun_flag, .data_avail_flag, .tx_empty_flag, .status_oe_n, .irq);
  aur_station i_aur_station (.rx_bit_clock, .tx_bit_clock, .serial_out, .frame_bits,
    .serial_in);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Bit clocks unrelated to each other and to clk
  initial begin
    tx_bit_clock = 1'b0;
    forever #110 tx_bit_clock = ~tx_bit_clock;
  end
  initial begin
    rx_bit_clock = 1'b0;
    forever #130 rx_bit_clock = ~rx_bit_clock;
  end
  function automatic int flen(input logic [4:0] c);
    flen = 7 + int'(c[1:0]) + int'(!c[4]) + int'(c[2]);
  endfunction
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [4:0] c,
                                        input logic [1:0] bad);
    int n;
    logic p;
    logic [11:0] f;
    n = 5 + int'(c[1:0]);
    f = 12'hFFF;
    f[0] = 1'b0;
    p = ~c[3];
    for (int i = 0; i < n; i++) begin
      f[i + 1] = d[i];
      p = p ^ d[i];
    end
    if (!c[4]) begin
      f[n + 1] = p ^ bad[0];
      n++;
    end
    f[n + 1] = ~bad[1];
    frame = f;
  endfunction
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    `CHK("bus_answer", 1'b1, n < 50)
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] ex);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK("read", ex, r)
  endtask
  task automatic t_reset;
    logic [9:0] pins;
    pins = {serial_out, end_of_char, tx_empty_flag, data_avail_flag, parity_fault_flag,
            framing_fault_flag, overrun_flag, irq, rx_parallel_oe_n, status_oe_n};
    `CHK("reset_pins", 10'h383, pins)
    rd_chk(aur_pkg::ADDR_CTRL, 32'h0);
    rd_chk(5'h02, 32'h0);
    rd_chk(aur_pkg::ADDR_STATUS, 32'h30);
    rx_data_enable_n <= 1'b0;
    status_enable_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("oe_n", 2'b00, {rx_parallel_oe_n, status_oe_n})
  endtask
  // Two writes back to back: the second must wait in the holding buffer
  task automatic t_tx(input logic [4:0] c);
    int n;
    logic [11:0] mk;
    mk = 12'((32'h1 << flen(c)) - 32'h1);
    wr(aur_pkg::ADDR_CTRL, {27'h0, c});
    frame_bits = 4'(flen(c));
    i_aur_station.frames.delete();
    wr(aur_pkg::ADDR_TXDATA, 32'hA5);
    wr(aur_pkg::ADDR_TXDATA, 32'h3C);
    repeat (2) @(posedge clk);
    `CHK("tx_empty", 1'b0, tx_empty_flag)
    n = 0;
    while (i_aur_station.frames.size() < 2 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    `CHK("frame_a", frame(8'hA5, c, 2'b00) & mk, i_aur_station.frames[0])
    `CHK("frame_b", frame(8'h3C, c, 2'b00) & mk, i_aur_station.frames[1])
    repeat (80) @(posedge clk);
    `CHK("tx_idle", 3'h7, {serial_out, end_of_char, tx_empty_flag})
  endtask
  task automatic t_rx(input logic [4:0] c, input logic [7:0] d, input logic [1:0] bad,
                      input logic ov, input logic take);
    logic [7:0] m;
    m = 8'hFF >> (3 - c[1:0]);
    wr(aur_pkg::ADDR_CTRL, {27'h0, c});
    i_aur_station.send(frame(d, c, bad), flen(c));
    `CHK("rx_data", d & m, rx_parallel_out)
    `CHK("rx_perr", bad[0] & ~c[4], parity_fault_flag)
    `CHK("rx_ferr", bad[1], framing_fault_flag)
    `CHK("rx_ovr", ov, overrun_flag)
    `CHK("rx_dav", 1'b1, data_avail_flag)
    if (take) begin
      rd_chk(aur_pkg::ADDR_RXDATA, {24'h0, d & m});
      repeat (2) @(posedge clk);
      `CHK("rx_dav_read", 1'b0, data_avail_flag)
    end
  endtask
  // Transmit event stays set but masked, so irq must drop with the receive bit
  task automatic t_irq;
    `CHK("irq_on", 1'b1, irq)
    rd_chk(aur_pkg::ADDR_IRQ_STATUS, 32'h3);
    wr(aur_pkg::ADDR_IRQ_CLEAR, 32'h1);
    @(posedge clk);
    `CHK("irq_masked", 1'b0, irq)
    rd_chk(aur_pkg::ADDR_IRQ_STATUS, 32'h2);
  endtask
  // Pin clear first, then the register clear cutting a frame just started
  task automatic t_clear;
    logic [5:0] st;
    @(posedge clk);
    master_clear <= 1'b1;
    repeat (8) @(posedge clk);
    master_clear <= 1'b0;
    repeat (4) @(posedge clk);
    st = {serial_out, tx_empty_flag, data_avail_flag, overrun_flag, framing_fault_flag,
          parity_fault_flag};
    `CHK("cleared", 6'h30, st)
    wr(aur_pkg::ADDR_TXDATA, 32'h55);
    repeat (2) @(posedge clk);
    `CHK("tx_started", 1'b0, serial_out)
    wr(aur_pkg::ADDR_CLEAR, 32'h0);
    @(posedge clk);
    `CHK("reg_clear", 3'h7, {serial_out, end_of_char, tx_empty_flag})
    rd_chk(aur_pkg::ADDR_CTRL, {27'h0, FMT[1]});
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    stop_test;
  end
  initial begin
    reset_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    master_clear = 1'b0;
    rx_data_enable_n = 1'b1;
    status_enable_n = 1'b1;
    frame_bits = 4'hC;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    for (int i = 0; i < 4; i++) t_tx(FMT[i]);
    wr(aur_pkg::ADDR_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 4; i++) t_rx(FMT[i], 8'hC3 ^ 8'(i), 2'b00, 1'b0, 1'b1);
    t_irq;
    t_rx(FMT[0], 8'h5A, 2'b01, 1'b0, 1'b1);
    t_rx(FMT[2], 8'h5A, 2'b01, 1'b0, 1'b1);
    t_rx(FMT[3], 8'h11, 2'b00, 1'b0, 1'b0);
    t_rx(FMT[3], 8'h22, 2'b00, 1'b1, 1'b1);
    t_rx(FMT[1], 8'h0F, 2'b10, 1'b0, 1'b0);
    t_clear;
    stop_test;
  end
endmodule // aur_top_tb_top
